// *** hdl/ppg_timer_pkg.sv ***
// ****************************************
// constants and carriers
// ****************************************
package ppg_timer_pkg;

  localparam int unsigned ADDR_W = 5;

  localparam logic [4:0] OFF_LOWER_TIMER_CONTROL = 5'h00;
  localparam logic [4:0] OFF_UPPER_TIMER_CONTROL = 5'h04;
  localparam logic [4:0] OFF_WIDTH_COMPARE_LOW = 5'h08;
  localparam logic [4:0] OFF_WIDTH_COMPARE_HIGH = 5'h0C;
  localparam logic [4:0] OFF_PERIOD_COMPARE_LOW = 5'h10;
  localparam logic [4:0] OFF_PERIOD_COMPARE_HIGH = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;

  localparam int unsigned RUN_BIT = 3;
  localparam int unsigned INIT_BIT = 7;
  localparam int unsigned MODE_BIT = 0;
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned ST_FF_BIT = 16;
  localparam int unsigned ST_RUN_BIT = 17;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_DIV_A = 2'b01,
    SRC_DIV_B = 2'b10,
    SRC_DIRECT = 2'b11
  } src_t;

  typedef enum logic {
    MODE_PULSE = 1'b0,
    MODE_WARMUP = 1'b1
  } mode_t;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] WARM_LOW_BYTE = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_MIN = 16'h0100;
  localparam logic [15:0] PERIOD_MAX = 16'hFF00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avs_rsp_t;

endpackage : ppg_timer_pkg

// *** hdl/cascaded_pulse_gen_warmup_timer.sv ***
// Functional notes
// - counter advances on internal or pin source
// - width match inverts output, keeps counting
// - period match inverts, clears, raises interrupt
// - output flop loads initial level, resets 0
// - pulse pin drives inverse of flop
// - compare registers act at once, unbuffered
// - stopped pin holds; level changed after stop
// - run bit 3, level bit 7
// - warm-up compares only period upper byte
// - warm-up match clears counter, raises interrupt
// - slow clock gives 7.81 ms to 1.99 s
// - fast clock gives 16 us to 4.08 ms
// - run bit starts at 1, stops at 0
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
module cascaded_pulse_gen_warmup_timer #(
  parameter int unsigned PRESC_W = 8,
  parameter int unsigned DIV_A_LOG2 = 3,
  parameter int unsigned DIV_B_LOG2 = 7
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire ppg_timer_pkg::avs_req_t I_AVS_REQ,
  input wire logic I_EXT_EVENT,
  output ppg_timer_pkg::avs_rsp_t O_AVS_RSP,
  output logic O_PULSE_OUT_N,
  output logic O_IRQ
);

  // ****************************************
  // parameter check
  // ****************************************
  if (DIV_A_LOG2 < 1 || DIV_A_LOG2 >= PRESC_W ||
      DIV_B_LOG2 < 1 || DIV_B_LOG2 >= PRESC_W) begin : g_bad_div
    $error("divider exponents must be 1 .. PRESC_W-1");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] lower_timer_control;
    logic [7:0] upper_timer_control;
    logic [7:0] width_compare_low;
    logic [7:0] width_compare_high;
    logic [7:0] period_compare_low;
    logic [7:0] period_compare_high;
    logic [15:0] cnt;
    logic [PRESC_W-1:0] presc;
    logic output_flipflop;
    logic pin_n;
    logic irq;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic waitreq;
    logic [31:0] rdata;
  } st_t;

  localparam st_t ST_RST = '{
    lower_timer_control: ppg_timer_pkg::CTRL_RST,
    upper_timer_control: ppg_timer_pkg::CTRL_RST,
    width_compare_low: ppg_timer_pkg::CMP_RST,
    width_compare_high: ppg_timer_pkg::CMP_RST,
    period_compare_low: ppg_timer_pkg::CMP_RST,
    period_compare_high: ppg_timer_pkg::CMP_RST,
    cnt: ppg_timer_pkg::CNT_RST,
    presc: '0,
    output_flipflop: 1'b0,
    pin_n: 1'b1,
    irq: 1'b0,
    ext_s1: 1'b1,
    ext_s2: 1'b1,
    ext_s3: 1'b1,
    waitreq: 1'b1,
    rdata: ppg_timer_pkg::RD_ZERO
  };

  st_t st_r;
  st_t st_nxt;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_off(
    input logic [ppg_timer_pkg::ADDR_W-1:0] a,
    input logic [ppg_timer_pkg::ADDR_W-1:0] off
  );
    return a == off;
  endfunction : is_off

  // all low k bits of the prescaler set marks one divided tick
  function automatic logic presc_tick(
    input logic [PRESC_W-1:0] p,
    input int unsigned k
  );
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((1 << k) - 1);
    return &(p | ~m);
  endfunction : presc_tick

  ppg_timer_pkg::src_t src;
  ppg_timer_pkg::mode_t mode;
  logic run;
  logic ext_fall;
  logic tick_src;
  logic tick;
  logic [15:0] width_val;
  logic [15:0] period_val;
  logic width_hit;
  logic period_hit;
  logic bus_go;
  logic bus_commit;
  logic up_wr;

  assign src = ppg_timer_pkg::src_t'(
    st_r.lower_timer_control[ppg_timer_pkg::SRC_LSB +: 2]);
  assign mode = ppg_timer_pkg::mode_t'(
    st_r.upper_timer_control[ppg_timer_pkg::MODE_BIT]);
  assign run = st_r.upper_timer_control[ppg_timer_pkg::RUN_BIT];

  // falling edge of the synchronised pin; s1 feeds only s2
  assign ext_fall = st_r.ext_s3 & ~st_r.ext_s2;

  always_comb begin
    case (src)
      ppg_timer_pkg::SRC_EXT: tick_src = ext_fall;
      ppg_timer_pkg::SRC_DIV_A: tick_src = presc_tick(st_r.presc, DIV_A_LOG2);
      ppg_timer_pkg::SRC_DIV_B: tick_src = presc_tick(st_r.presc, DIV_B_LOG2);
      default: tick_src = 1'b1;
    endcase
  end

  // a stopped counter sees no tick, hence no match either
  assign tick = run & tick_src;

  // compare registers are read live, no shadow copy
  assign width_val = {st_r.width_compare_high, st_r.width_compare_low};
  assign period_val = (mode == ppg_timer_pkg::MODE_WARMUP) ?
    {st_r.period_compare_high, ppg_timer_pkg::WARM_LOW_BYTE} :
    {st_r.period_compare_high, st_r.period_compare_low};
  assign width_hit = (mode == ppg_timer_pkg::MODE_PULSE) &&
    (st_r.cnt == width_val);
  assign period_hit = (st_r.cnt == period_val);

  assign bus_go = (I_AVS_REQ.read | I_AVS_REQ.write) & st_r.waitreq;
  assign bus_commit = I_AVS_REQ.write & ~st_r.waitreq &
    I_AVS_REQ.byteenable[0];
  assign up_wr = bus_commit &&
    is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ext_s1 = I_EXT_EVENT;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;
    st_nxt.irq = 1'b0;
    if (run) begin
      st_nxt.presc = st_r.presc + 1'b1;
    end
    if (tick) begin
      if (period_hit) begin
        st_nxt.cnt = ppg_timer_pkg::CNT_RST;
        st_nxt.irq = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
      // both compares hitting at once cancel each other on the flop
      st_nxt.output_flipflop = st_r.output_flipflop ^ width_hit ^
        (period_hit && mode == ppg_timer_pkg::MODE_PULSE);
    end
    // register access: waitrequest drops for one cycle per request
    if (bus_go) begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata = ppg_timer_pkg::RD_ZERO;
      if (I_AVS_REQ.read) begin
        if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_LOWER_TIMER_CONTROL)) begin
          st_nxt.rdata[7:0] = st_r.lower_timer_control;
        end else if (is_off(I_AVS_REQ.address,
                            ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL)) begin
          st_nxt.rdata[7:0] = st_r.upper_timer_control;
        end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_WIDTH_COMPARE_LOW)) begin
          st_nxt.rdata[7:0] = st_r.width_compare_low;
        end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_WIDTH_COMPARE_HIGH)) begin
          st_nxt.rdata[7:0] = st_r.width_compare_high;
        end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_PERIOD_COMPARE_LOW)) begin
          st_nxt.rdata[7:0] = st_r.period_compare_low;
        end else if (is_off(I_AVS_REQ.address,
                            ppg_timer_pkg::OFF_PERIOD_COMPARE_HIGH)) begin
          st_nxt.rdata[7:0] = st_r.period_compare_high;
        end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_STATUS)) begin
          st_nxt.rdata[15:0] = st_r.cnt;
          st_nxt.rdata[ppg_timer_pkg::ST_FF_BIT] = st_r.output_flipflop;
          st_nxt.rdata[ppg_timer_pkg::ST_RUN_BIT] = run;
        end
      end
    end else if (!st_r.waitreq) begin
      st_nxt.waitreq = 1'b1;
    end
    if (bus_commit) begin
      if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_LOWER_TIMER_CONTROL)) begin
        st_nxt.lower_timer_control = I_AVS_REQ.writedata[7:0];
      end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL)) begin
        st_nxt.upper_timer_control = I_AVS_REQ.writedata[7:0];
      end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_WIDTH_COMPARE_LOW)) begin
        st_nxt.width_compare_low = I_AVS_REQ.writedata[7:0];
      end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_WIDTH_COMPARE_HIGH)) begin
        st_nxt.width_compare_high = I_AVS_REQ.writedata[7:0];
      end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_PERIOD_COMPARE_LOW)) begin
        st_nxt.period_compare_low = I_AVS_REQ.writedata[7:0];
      end else if (is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_PERIOD_COMPARE_HIGH)) begin
        st_nxt.period_compare_high = I_AVS_REQ.writedata[7:0];
      end
    end
    // level bit is taken only while stopped, so a running pulse is never cut
    if (up_wr && !run) begin
      st_nxt.output_flipflop = I_AVS_REQ.writedata[ppg_timer_pkg::INIT_BIT];
    end
    st_nxt.pin_n = ~st_nxt.output_flipflop;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_r <= ST_RST;
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  assign O_AVS_RSP.readdata = st_r.rdata;
  assign O_AVS_RSP.waitrequest = st_r.waitreq;
  assign O_PULSE_OUT_N = st_r.pin_n;
  assign O_IRQ = st_r.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST || !I_CE);

  // a zero period matches on every tick, so back-to-back pulses are legal there
  property p_irq_single;
    O_IRQ && !(tick && period_hit) |=> !O_IRQ;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("irq longer than one cycle");

  property p_pin_inverse;
    O_PULSE_OUT_N == !st_r.output_flipflop;
  endproperty
  a_pin_inverse: assert property (p_pin_inverse) else $error("pin not inverse of flop");

  property p_period_match;
    tick && period_hit && mode == ppg_timer_pkg::MODE_PULSE && !width_hit
      |=> st_r.cnt == 16'h0000 && O_IRQ &&
          st_r.output_flipflop != $past(st_r.output_flipflop);
  endproperty
  a_period_match: assert property (p_period_match) else $error("period match failed");

  property p_width_match;
    tick && width_hit && !period_hit
      |=> st_r.cnt == $past(st_r.cnt) + 16'h0001 && !O_IRQ &&
          st_r.output_flipflop != $past(st_r.output_flipflop);
  endproperty
  a_width_match: assert property (p_width_match) else $error("width match failed");

  property p_warm_match;
    tick && mode == ppg_timer_pkg::MODE_WARMUP &&
      st_r.cnt == {st_r.period_compare_high, ppg_timer_pkg::WARM_LOW_BYTE}
      |=> O_IRQ && st_r.cnt == 16'h0000 && $stable(st_r.output_flipflop);
  endproperty
  a_warm_match: assert property (p_warm_match) else $error("warm-up match failed");

  property p_stop_freeze;
    !run |=> $stable(st_r.cnt) && !O_IRQ;
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("stopped counter moved");

  property p_stop_hold;
    !run && !up_wr |=> $stable(O_PULSE_OUT_N);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped pin changed");

  property p_level_load;
    up_wr && !run
      |=> O_PULSE_OUT_N == !$past(I_AVS_REQ.writedata[ppg_timer_pkg::INIT_BIT]);
  endproperty
  a_level_load: assert property (p_level_load) else $error("level bit not loaded");

  property p_ext_tick;
    tick && src == ppg_timer_pkg::SRC_EXT |-> st_r.ext_s3 && !st_r.ext_s2;
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("pin count without edge");

  property p_bus_answer;
    bus_go |=> !O_AVS_RSP.waitrequest ##1 O_AVS_RSP.waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

  property p_irq_cause;
    O_IRQ |-> $past(tick && period_hit);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without period match");

  property p_cmp_live;
    bus_commit && is_off(I_AVS_REQ.address, ppg_timer_pkg::OFF_PERIOD_COMPARE_HIGH)
      |=> st_r.period_compare_high == $past(I_AVS_REQ.writedata[7:0]);
  endproperty
  a_cmp_live: assert property (p_cmp_live) else $error("compare byte not taken at once");

  property p_cov_pulse;
    tick && period_hit && mode == ppg_timer_pkg::MODE_PULSE;
  endproperty
  c_cov_pulse: cover property (p_cov_pulse);

  property p_cov_warm;
    tick && period_hit && mode == ppg_timer_pkg::MODE_WARMUP;
  endproperty
  c_cov_warm: cover property (p_cov_warm);

  property p_cov_ext;
    tick && src == ppg_timer_pkg::SRC_EXT;
  endproperty
  c_cov_ext: cover property (p_cov_ext);

  property p_cov_stop;
    $fell(run);
  endproperty
  c_cov_stop: cover property (p_cov_stop);

endmodule : cascaded_pulse_gen_warmup_timer

// *** verification/event_pin_model.sv ***
// ****************************************
// far side: event pin source and pulse pin load
// ****************************************
module event_pin_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic en,
  input wire logic pulse_n,
  output logic ev,
  output logic load_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic port_latch = 1'b1;
  initial ev = 1'b1;
  // line idles high between bursts so no stray falling edge is counted
  always @(posedge clk) begin
    if (!en) begin
      ev <= 1'b1;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      ev <= ~ev;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign load_lvl = port_latch & pulse_n;
endmodule : event_pin_model

// *** verification/cascaded_pulse_gen_warmup_timer_tb_top.sv ***
module cascaded_pulse_gen_warmup_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ev_en = 1'b0;
  logic ce = 1'b1;
  logic ev;
  logic pin_n;
  logic irq;
  logic load_lvl;
  ppg_timer_pkg::avs_req_t req = '0;
  ppg_timer_pkg::avs_rsp_t rsp;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int irq_cnt = 0;
  logic [31:0] seed = 32'h0000_e99b;
  logic [31:0] rd;
  logic [31:0] a;
  logic p0;

  always #5 clk = ~clk;

  cascaded_pulse_gen_warmup_timer dut_u (
    .I_SYS_CLK(clk),
    .I_RST(rst),
    .I_CE(ce),
    .I_AVS_REQ(req),
    .I_EXT_EVENT(ev),
    .O_AVS_RSP(rsp),
    .O_PULSE_OUT_N(pin_n),
    .O_IRQ(irq)
  );

  event_pin_model #(.HALF(8)) far_u (
    .clk(clk),
    .en(ev_en),
    .pulse_n(pin_n),
    .ev(ev),
    .load_lvl(load_lvl)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int exp_ticks(input int n, input int sp);
    return n * sp;
  endfunction : exp_ticks

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low, then released
  // no local limit: a slave that never answers is caught by the cycle ceiling
  task automatic bus(input logic [4:0] adr, input logic w, input logic [31:0] d);
    req <= '{address: adr, read: ~w, write: w, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata;
    req <= '0;
    @(posedge clk);
  endtask : bus

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 9000);
    if (n >= 9000) error_cnt++;
  endtask : wait_irq

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 90000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [1:0] srcs [4];
    int sps [4];
    int w;
    int p;
    int n;
    int nw;
    logic lvl;
    srcs = '{2'b11, 2'b01, 2'b10, 2'b00};
    sps = '{1, 8, 128, 16};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(pin_n, 1'b1);
    check(irq, 1'b0);
    bus(ppg_timer_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(5'h1C, 1'b1, 32'h0000_00ff);
    bus(5'h1C, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      lvl = i[0];
      seed = lfsr(seed);
      w = 1 + int'(seed[2:0]);
      p = w + 2 + int'(seed[7:4]);
      bus(ppg_timer_pkg::OFF_WIDTH_COMPARE_LOW, 1'b1, 32'(w));
      bus(ppg_timer_pkg::OFF_WIDTH_COMPARE_HIGH, 1'b1, 32'h0000_0000);
      bus(ppg_timer_pkg::OFF_PERIOD_COMPARE_LOW, 1'b1, 32'(p));
      bus(ppg_timer_pkg::OFF_PERIOD_COMPARE_HIGH, 1'b1, 32'h0000_0000);
      bus(ppg_timer_pkg::OFF_WIDTH_COMPARE_LOW, 1'b0, 32'h0000_0000);
      check(rd, 32'(w));
      bus(ppg_timer_pkg::OFF_LOWER_TIMER_CONTROL, 1'b1, {30'h0, srcs[i]});
      ev_en <= (i == 3);
      bus(ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL, 1'b1, {24'h0, lvl, 7'h00});
      repeat (2) @(posedge clk);
      check(pin_n, !lvl);
      bus(ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL, 1'b1, {24'h0, lvl, 7'h08});
      wait_irq(n);
      check(pin_n, !lvl);
      @(posedge clk);
      check(irq, 1'b0);
      nw = 1;
      while (pin_n === ~lvl && nw < 9000) begin
        @(posedge clk);
        nw++;
      end
      check(nw, exp_ticks(w + 1, sps[i]));
      wait_irq(n);
      check(n + nw, exp_ticks(p + 1, sps[i]));
      bus(ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL, 1'b1, {24'h0, lvl, 7'h00});
      p0 = pin_n;
      n = irq_cnt;
      bus(ppg_timer_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
      a = rd;
      repeat (40) @(posedge clk);
      bus(ppg_timer_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
      check(rd[15:0], a[15:0]);
      check(irq_cnt, n);
      check(pin_n, p0);
      bus(ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL, 1'b1, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check(pin_n, 1'b1);
      check(load_lvl, 1'b1);
      ev_en <= 1'b0;
      $display("test pulse source %0d done", i);
    end
    // warm-up: low byte of period must be ignored
    for (int k = 1; k < 3; k++) begin
      seed = lfsr(seed);
      bus(ppg_timer_pkg::OFF_LOWER_TIMER_CONTROL, 1'b1, 32'h0000_0003);
      bus(ppg_timer_pkg::OFF_PERIOD_COMPARE_LOW, 1'b1, {24'h0, seed[7:0] | 8'h01});
      bus(ppg_timer_pkg::OFF_PERIOD_COMPARE_HIGH, 1'b1, 32'(k));
      bus(ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL, 1'b1, 32'h0000_0009);
      wait_irq(n);
      // frozen cycles must not count towards the interval
      ce <= 1'b0;
      repeat (30) @(posedge clk);
      ce <= 1'b1;
      wait_irq(n);
      check(n, exp_ticks(k * 256 + 1, 1));
      check(pin_n, 1'b1);
      bus(ppg_timer_pkg::OFF_UPPER_TIMER_CONTROL, 1'b1, 32'h0000_0001);
      $display("test warm-up %0d done", k);
    end
    print_verdict();
  end
endmodule : cascaded_pulse_gen_warmup_timer_tb_top
